//--- hdl/dpm_pin_mux.sv
// Pin-function selection for the byte-wide memory companion's ports and strobes.
// Assumes flash, page-register writers and logic arrays sit outside; one clock mclk.
// Summary of operation
// - Reset clears ports, page and configuration
// - Third control input is byte-space select
// - Port B pins: general, macrocell or input
// - Port B 0-3 choose slew rate
// - Port B 3-7 choose open-drain
// - Port C 0,1,5,6 carry test access
// - Port C 3,4 carry programming status/error
// - Port C 3 may show ready/busy
// - Port C general pins choose open-drain
// - Port D inputs feed logic through the sync flops only
// - Port D may drive logic chip selects
// - Port D 1 may be logic clock
// - Port D 2 low selects flash
// - Port A is byte-wide data bus
// - First two inputs are write, read strobes
`timescale 1ns/1ps
module dpm_pin_mux
  import dpm_pkg::*;
(
  // Clock, reset, enable
  input  wire logic                 mclk,
  input  wire logic                 rst,
  input  wire logic                 ce,
  input  wire logic                 sys_reset_n,
  // Processor strobes
  input  wire logic                 write_strobe_in,
  input  wire logic                 read_strobe_in,
  input  wire logic                 byte_space_select_in,
  output logic                      bus_write_n,
  output logic                      bus_read_n,
  output logic                      byte_access,
  // Data byte pins
  input  wire logic [PORT_W-1:0]    data_byte_pins_i,
  output logic      [PORT_W-1:0]    data_byte_pins_o,
  output logic      [PORT_W-1:0]    data_byte_pins_oe_n,
  output logic      [PORT_W-1:0]    data_in,
  input  wire logic [PORT_W-1:0]    data_out,
  input  wire logic                 data_drive,
  // Page register load
  input  wire logic                 page_we,
  output logic      [2:0]           page,
  // Configuration writes (from the control block)
  input  wire logic                 cfg_we,
  input  wire logic [2*PORT_W-1:0]  pb_fn_wr,
  input  wire logic [PORT_W-1:0]    pb_out_wr,
  input  wire logic [PORT_W-1:0]    pb_dir_wr,
  input  wire logic [3:0]           pb_slew_wr,
  input  wire logic [4:0]           pb_od_wr,
  input  wire logic [PORT_W-1:0]    pc_out_wr,
  input  wire logic [PORT_W-1:0]    pc_dir_wr,
  input  wire logic [PORT_W-1:0]    pc_od_wr,
  input  wire logic [PORT_W-1:0]    pc_mcell_wr,
  input  wire logic [PORTD_W-1:0]   pd_out_wr,
  input  wire logic [PORTD_W-1:0]   pd_dir_wr,
  input  wire logic [PORTD_W-1:0]   pd_cs_wr,
  // Static options
  input  wire logic                 opt_jtag,
  input  wire logic                 opt_prog_stat,
  input  wire logic                 opt_ready_busy,
  input  wire logic                 opt_clk_in,
  input  wire logic                 opt_flash_csel,
  // Port B
  input  wire logic [PORT_W-1:0]    port_b_pins_i,
  output logic      [PORT_W-1:0]    port_b_pins_o,
  output logic      [PORT_W-1:0]    port_b_pins_oe_n,
  output logic      [3:0]           port_b_fast_slew,
  output logic      [PORT_W-1:0]    port_b_open_drain,
  // Port C
  input  wire logic [PORT_W-1:0]    port_c_pins_i,
  output logic      [PORT_W-1:0]    port_c_pins_o,
  output logic      [PORT_W-1:0]    port_c_pins_oe_n,
  output logic      [PORT_W-1:0]    port_c_open_drain,
  // Port D
  input  wire logic [PORTD_W-1:0]   port_d_pins_i,
  output logic      [PORTD_W-1:0]   port_d_pins_o,
  output logic      [PORTD_W-1:0]   port_d_pins_oe_n,
  // Macrocell and logic array side
  input  wire logic [PORT_W-1:0]    output_macrocells_first_group,
  input  wire logic [PORT_W-1:0]    output_macrocells_second_group,
  input  wire logic [PORTD_W-1:0]   logic_chip_selects,
  output logic      [PORT_W-1:0]    port_b_logic_in,
  output logic      [PORT_W-1:0]    port_c_logic_in,
  output logic      [PORTD_W-1:0]   port_d_logic_in,
  output logic                      logic_common_clock,
  // Test and status
  output logic                      tms,
  output logic                      tck,
  output logic                      tdi,
  input  wire logic                 tdo,
  input  wire logic                 program_status_pin,
  input  wire logic                 program_error_pin,
  input  wire logic                 flash_busy,
  output logic                      flash_enable,
  // General I/O readback
  output logic      [PORT_W-1:0]    pb_read,
  output logic      [PORT_W-1:0]    pc_read,
  output logic      [PORTD_W-1:0]   pd_read
);
  logic [2*PORT_W-1:0] pb_fn_q, pb_fn_d;
  logic [PORT_W-1:0]   pb_out_q, pb_out_d, pb_dir_q, pb_dir_d;
  logic [3:0]          pb_slew_q, pb_slew_d;
  logic [4:0]          pb_od_q, pb_od_d;
  logic [PORT_W-1:0]   pc_out_q, pc_out_d, pc_dir_q, pc_dir_d;
  logic [PORT_W-1:0]   pc_od_q, pc_od_d, pc_mc_q, pc_mc_d;
  logic [PORTD_W-1:0]  pd_out_q, pd_out_d, pd_dir_q, pd_dir_d, pd_cs_q, pd_cs_d;
  logic [2:0]          page_q, page_d;
  logic [PORT_W-1:0]   dat_q, dat_d;
  logic                rstn_s, clr;
  logic [2:0]          strb_s;
  logic [PORT_W-1:0]   pa_s, pb_s, pc_s;
  logic [PORTD_W-1:0]  pd_s;
  logic [PORT_W-1:0]   pc_ded;

  // Pins cross into mclk through two flops each
  // Active-low strobes must come out of reset idle, or a false access shows
  dpm_sync #(.W(4), .RST(CTL_SYNC_RST)) u_sync_ctl (
    .mclk (mclk),
    .rst  (rst),
    .ce   (ce),
    .d    ({sys_reset_n, byte_space_select_in, read_strobe_in, write_strobe_in}),
    .q    ({rstn_s, strb_s})
  );
  dpm_sync #(.W(3*PORT_W+PORTD_W)) u_sync_pins (
    .mclk (mclk),
    .rst  (rst),
    .ce   (ce),
    .d    ({data_byte_pins_i, port_b_pins_i, port_c_pins_i, port_d_pins_i}),
    .q    ({pa_s, pb_s, pc_s, pd_s})
  );

  function automatic dpm_fn_t fn_of(input logic [2*PORT_W-1:0] f, input int i);
    fn_of = dpm_fn_t'(f[2*i +: 2]);
  endfunction

  assign clr = ~rstn_s;

  always_comb begin
    pb_fn_d = pb_fn_q;   pb_out_d = pb_out_q; pb_dir_d = pb_dir_q;
    pb_slew_d = pb_slew_q; pb_od_d = pb_od_q;
    pc_out_d = pc_out_q; pc_dir_d = pc_dir_q; pc_od_d = pc_od_q; pc_mc_d = pc_mc_q;
    pd_out_d = pd_out_q; pd_dir_d = pd_dir_q; pd_cs_d = pd_cs_q;
    page_d = page_q;
    dat_d = pa_s;
    if (clr) begin
      // System reset returns runtime state to defaults
      pb_fn_d = '0; pb_out_d = GPIO_OUT_RST; pb_dir_d = GPIO_DIR_RST;
      pb_slew_d = DRIVE_RST[3:0]; pb_od_d = DRIVE_RST[4:0];
      pc_out_d = GPIO_OUT_RST; pc_dir_d = GPIO_DIR_RST;
      pc_od_d = DRIVE_RST; pc_mc_d = DRIVE_RST;
      pd_out_d = PD_RST; pd_dir_d = PD_RST; pd_cs_d = PD_RST;
      page_d = PAGE_RST;
    end else begin
      if (cfg_we) begin
        pb_fn_d = pb_fn_wr; pb_out_d = pb_out_wr; pb_dir_d = pb_dir_wr;
        pb_slew_d = pb_slew_wr;
        pb_od_d = pb_od_wr;
        pc_out_d = pc_out_wr; pc_dir_d = pc_dir_wr;
        pc_od_d = pc_od_wr;
        pc_mc_d = pc_mc_wr_f(pc_mcell_wr);
        pd_out_d = pd_out_wr; pd_dir_d = pd_dir_wr; pd_cs_d = pd_cs_wr;
      end
      if (page_we) begin
        page_d = data_in[2:0];
      end
    end
  end

  function automatic logic [PORT_W-1:0] pc_mc_wr_f(input logic [PORT_W-1:0] v);
    pc_mc_wr_f = v;
  endfunction

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pb_fn_q <= '0; pb_out_q <= GPIO_OUT_RST; pb_dir_q <= GPIO_DIR_RST;
      pb_slew_q <= DRIVE_RST[3:0]; pb_od_q <= DRIVE_RST[4:0];
      pc_out_q <= GPIO_OUT_RST; pc_dir_q <= GPIO_DIR_RST;
      pc_od_q <= DRIVE_RST; pc_mc_q <= DRIVE_RST;
      pd_out_q <= PD_RST; pd_dir_q <= PD_RST; pd_cs_q <= PD_RST;
      page_q <= PAGE_RST; dat_q <= '0;
    end else if (ce) begin
      pb_fn_q <= pb_fn_d; pb_out_q <= pb_out_d; pb_dir_q <= pb_dir_d;
      pb_slew_q <= pb_slew_d; pb_od_q <= pb_od_d;
      pc_out_q <= pc_out_d; pc_dir_q <= pc_dir_d; pc_od_q <= pc_od_d; pc_mc_q <= pc_mc_d;
      pd_out_q <= pd_out_d; pd_dir_q <= pd_dir_d; pd_cs_q <= pd_cs_d;
      page_q <= page_d; dat_q <= dat_d;
    end
  end

  // Strobes after synchronisation
  assign bus_write_n = strb_s[0];
  assign bus_read_n  = strb_s[1];
  assign byte_access = ~strb_s[2] & ~(strb_s[0] & strb_s[1]);
  assign page        = page_q;

  // Data byte bus, driven only when the array answers a read
  assign data_in             = dat_q;
  assign data_byte_pins_o    = data_out;
  assign data_byte_pins_oe_n = {PORT_W{~(data_drive & ~strb_s[1])}};

  // Port B
  always_comb begin
    for (int i = 0; i < PORT_W; i++) begin
      case (fn_of(pb_fn_q, i))
        DPM_FN_GPIO: begin
          port_b_pins_o[i] = pb_out_q[i];
          port_b_pins_oe_n[i] = ~pb_dir_q[i];
        end
        DPM_FN_MCELL: begin
          port_b_pins_o[i] = i < 4 ? output_macrocells_first_group[i]
                                   : output_macrocells_second_group[i];
          port_b_pins_oe_n[i] = 1'b0;
        end
        default: begin
          port_b_pins_o[i] = 1'b0;
          port_b_pins_oe_n[i] = 1'b1;
        end
      endcase
    end
  end
  assign port_b_fast_slew  = pb_slew_q;
  assign port_b_open_drain = {pb_od_q, 3'h0};
  assign port_b_logic_in   = pb_s;
  assign pb_read           = pb_s;

  // Port C dedicated pins override general and macrocell drive
  always_comb begin
    pc_ded = '0;
    if (opt_jtag) begin
      pc_ded[PC_TMS] = 1'b1; pc_ded[PC_TCK] = 1'b1;
      pc_ded[PC_TDI] = 1'b1; pc_ded[PC_TDO] = 1'b1;
    end
    if (opt_prog_stat | opt_ready_busy) begin
      pc_ded[PC_STAT] = 1'b1;
    end
    if (opt_prog_stat) begin
      pc_ded[PC_ERR] = 1'b1;
    end
    for (int i = 0; i < PORT_W; i++) begin
      port_c_pins_o[i] = pc_mc_q[i] ? output_macrocells_second_group[i] : pc_out_q[i];
      port_c_pins_oe_n[i] = ~(pc_mc_q[i] | pc_dir_q[i]);
      if (pc_ded[i]) begin
        port_c_pins_o[i] = 1'b0;
        port_c_pins_oe_n[i] = 1'b1;
      end
    end
    if (opt_jtag) begin
      port_c_pins_o[PC_TDO] = tdo;
      port_c_pins_oe_n[PC_TDO] = 1'b0;
    end
    if (opt_prog_stat) begin
      port_c_pins_o[PC_STAT] = program_status_pin;
      port_c_pins_o[PC_ERR] = program_error_pin;
      port_c_pins_oe_n[PC_STAT] = 1'b0;
      port_c_pins_oe_n[PC_ERR] = 1'b0;
    end else if (opt_ready_busy) begin
      port_c_pins_o[PC_STAT] = ~flash_busy;
      port_c_pins_oe_n[PC_STAT] = 1'b0;
    end
  end
  // Open-drain applies only to general pins
  assign port_c_open_drain = pc_od_q & ~pc_mc_q & ~pc_ded;
  assign tms = opt_jtag & pc_s[PC_TMS];
  assign tck = opt_jtag & pc_s[PC_TCK];
  assign tdi = opt_jtag & pc_s[PC_TDI];
  assign port_c_logic_in = pc_s & ~pc_ded;
  assign pc_read         = pc_s;

  // Port D: no input macrocell, synchronised pin straight to logic
  always_comb begin
    for (int i = 0; i < PORTD_W; i++) begin
      port_d_pins_o[i] = pd_cs_q[i] ? logic_chip_selects[i] : pd_out_q[i];
      port_d_pins_oe_n[i] = ~(pd_cs_q[i] | pd_dir_q[i]);
    end
    if (opt_clk_in) begin
      port_d_pins_o[PD_CLK] = 1'b0;
      port_d_pins_oe_n[PD_CLK] = 1'b1;
    end
    if (opt_flash_csel) begin
      port_d_pins_o[PD_CSEL] = 1'b0;
      port_d_pins_oe_n[PD_CSEL] = 1'b1;
    end
  end
  assign port_d_logic_in    = pd_s;
  assign logic_common_clock = opt_clk_in & pd_s[PD_CLK];
  // Flash disabled while select input is high, e.g. power-down acknowledge
  assign flash_enable       = ~opt_flash_csel | ~pd_s[PD_CSEL];
  assign pd_read            = pd_s;
endmodule

//--- hdl/dpm_pkg.sv
// Package for the memory-port pin mux: pin function codes, widths, reset values.
// Assumes a single mclk domain; all configuration arrives as plain ports.
package dpm_pkg;
  localparam int PORT_W      = 8;
  localparam int PORTD_W     = 3;
  // Pin function selection, two bits per pin
  typedef enum logic [1:0] {
    DPM_FN_GPIO   = 2'h0,
    DPM_FN_MCELL  = 2'h1,
    DPM_FN_INPUT  = 2'h2,
    DPM_FN_DEDIC  = 2'h3
  } dpm_fn_t;
  localparam logic [7:0] GPIO_OUT_RST = 8'h00;
  localparam logic [7:0] GPIO_DIR_RST = 8'h00;
  localparam logic [7:0] DRIVE_RST    = 8'h00;
  localparam logic [2:0] PAGE_RST     = 3'h0;
  localparam logic [2:0] PD_RST       = 3'h0;
  // Control sync: system reset starts asserted, strobes and byte select start idle high
  localparam logic [3:0] CTL_SYNC_RST = 4'h7;
  // Port C dedicated pin positions
  localparam int PC_TMS  = 0;
  localparam int PC_TCK  = 1;
  localparam int PC_STAT = 3;
  localparam int PC_ERR  = 4;
  localparam int PC_TDI  = 5;
  localparam int PC_TDO  = 6;
  // Port D dedicated pin positions
  localparam int PD_CLK  = 1;
  localparam int PD_CSEL = 2;
endpackage

//--- hdl/dpm_sync.sv
// Two-flop synchroniser bank for pin inputs.
// Assumes inputs are asynchronous to mclk.
`timescale 1ns/1ps
module dpm_sync #(
  parameter int           W   = 8,
  parameter logic [W-1:0] RST = '0
) (
  // Clock and reset
  input  wire logic         mclk,
  input  wire logic         rst,
  input  wire logic         ce,
  // Data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s1_d;
  logic [W-1:0] s2_q;
  logic [W-1:0] s2_d;

  always_comb begin
    s1_d = ce ? d : s1_q;
    s2_d = ce ? s1_q : s2_q;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s1_q <= RST;
      s2_q <= RST;
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
    end
  end

  assign q = s2_q;
endmodule

//--- tb/dpm_pin_mux_assertions.sv
// Checker for the pin mux: strobe sync, reset clearing, pin driver ownership.
// Assumes it is bound to dpm_pin_mux and that mclk is the only clock.
`timescale 1ns/1ps
module dpm_pin_mux_chk (
  // Clock, reset
  input wire logic       mclk,
  input wire logic       rst,
  input wire logic       sys_reset_n,
  // Bus side
  input wire logic       write_strobe_in,
  input wire logic       read_strobe_in,
  input wire logic       byte_space_select_in,
  input wire logic       bus_write_n,
  input wire logic       bus_read_n,
  input wire logic       byte_access,
  input wire logic       data_drive,
  input wire logic [7:0] data_byte_pins_oe_n,
  input wire logic [2:0] page,
  // Ports
  input wire logic [7:0] port_b_pins_oe_n,
  input wire logic [7:0] port_b_open_drain,
  input wire logic       opt_jtag,
  input wire logic       tdo,
  input wire logic [7:0] port_c_pins_o,
  input wire logic [7:0] port_c_pins_oe_n,
  input wire logic       opt_flash_csel,
  input wire logic [2:0] pd_read,
  input wire logic       flash_enable
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // Four samples cover the two sync flops plus the clearing edge
  sequence s_sys_rst; !sys_reset_n [*4]; endsequence
  sequence s_wr_idle; write_strobe_in [*4]; endsequence
  sequence s_rd_idle; read_strobe_in [*4]; endsequence
  cfg_clear_a: assert property (
    s_sys_rst |-> page == 3'h0 && port_b_pins_oe_n == 8'hFF)
    else $error("configuration not cleared under system reset");
  byte_sel_a: assert property (
    (!byte_space_select_in && !(write_strobe_in && read_strobe_in))[*4] |-> byte_access)
    else $error("byte access not flagged");
  wr_sync_a: assert property (s_wr_idle |-> bus_write_n)
    else $error("write strobe copy stuck low");
  rd_sync_a: assert property (s_rd_idle |-> bus_read_n)
    else $error("read strobe copy stuck low");
  od_low_a: assert property (port_b_open_drain[2:0] == 3'h0)
    else $error("open drain on low port B pins");
  data_oe_a: assert property (
    data_byte_pins_oe_n == ((data_drive && !bus_read_n) ? 8'h00 : 8'hFF))
    else $error("data byte driver wrong");
  tdo_route_a: assert property (
    opt_jtag |-> port_c_pins_o[6] == tdo && !port_c_pins_oe_n[6] && port_c_pins_oe_n[5])
    else $error("test pins misrouted");
  flash_sel_a: assert property (
    flash_enable == (!opt_flash_csel || !pd_read[2]))
    else $error("flash enable wrong");
endmodule
bind dpm_pin_mux dpm_pin_mux_chk u_chk (.mclk(mclk), .rst(rst), .sys_reset_n(sys_reset_n),
  .write_strobe_in(write_strobe_in), .read_strobe_in(read_strobe_in),
  .byte_space_select_in(byte_space_select_in), .bus_write_n(bus_write_n),
  .bus_read_n(bus_read_n), .byte_access(byte_access), .data_drive(data_drive),
  .data_byte_pins_oe_n(data_byte_pins_oe_n), .page(page), .port_b_pins_oe_n(port_b_pins_oe_n),
  .port_b_open_drain(port_b_open_drain), .opt_jtag(opt_jtag), .tdo(tdo),
  .port_c_pins_o(port_c_pins_o), .port_c_pins_oe_n(port_c_pins_oe_n),
  .opt_flash_csel(opt_flash_csel), .pd_read(pd_read), .flash_enable(flash_enable));

//--- tb/dpm_dsp_model.sv
// Processor model: strobes, byte select, data byte and the side pins it feeds.
// Assumes the bench calls start and side from a falling edge, then finish.
`timescale 1ns/1ps
module dpm_dsp_model (
  // Clock
  input wire logic       mclk,
  // Bus
  output logic           wr_n,
  output logic           rd_n,
  output logic           bms_n,
  output logic [7:0]     d_drv,
  input wire logic [7:0] d_wire,
  // Side pins
  output logic           dms_n,
  output logic           pwd_ack,
  output logic [1:0]     a_hi
);
  initial {wr_n, rd_n, bms_n, dms_n, pwd_ack, a_hi, d_drv} = 15'h7800;
  // Request stays until after the rising edge that samples the answer
  task automatic start(input logic rd, input logic byt, input logic [7:0] wv);
    bms_n = !byt;
    rd_n = !rd;
    wr_n = rd;
    if (!rd) d_drv = wv;
  endtask
  task automatic finish(output logic [7:0] rv);
    @(posedge mclk) rv = d_wire;
    @(negedge mclk) {wr_n, rd_n, bms_n} = 3'h7;
    d_drv = ~d_drv; // Released bus shows inverted data, never a stale copy
  endtask
  // Data select on PD1, power-down ack on PD2, upper address on PC2/PC7
  task automatic side(input logic dms, input logic pwd, input logic [1:0] ah);
    dms_n = dms;
    pwd_ack = pwd;
    a_hi = ah;
  endtask
endmodule

//--- tb/testbench.sv
// Bench for the pin mux: configures ports, drives pins and bus cycles, checks outputs.
// Assumes the processor model and the checker are compiled before it.
`timescale 1ns/1ps
module testbench;
  import dpm_pkg::*;
  logic mclk, rst, ce, srst_n, wr_n, rd_n, bms_n, bwr, brd, bacc, ddrv, pwe, cwe;
  logic ojt, ops, orb, ock, ocs, tms, tck, tdi, tdo, pst, per, fbsy, fen, lclk, dms_n, pwd;
  logic [1:0] a_hi;
  logic [2:0] page, pdo_w, pdd_w, pdc_w, pd_o, pd_oe, pd_i, pd_x, lcs, pd_li, pd_rd;
  logic [3:0] slw_w, slw;
  logic [4:0] pbod_w;
  logic [7:0] d_drv, dbus, dbo, dbo_oe, din, dout, pbo_w, pbd_w, pco_w, pcd_w, pcod_w, pcm_w;
  logic [7:0] pb_o, pb_oe, pb_od, pb_i, pb_x, pc_o, pc_oe, pc_od, pc_i, pc_x, mc1, mc2, pb_rd;
  logic [7:0] pc_li, rv, pb_li, pc_rd;
  logic [15:0] pbf_w;
  int failures, n_compared;
  // Pins resolve to the device where it drives, else to the outside party
  assign dbus = (~dbo_oe & dbo) | (dbo_oe & d_drv);
  assign pb_i = (~pb_oe & pb_o) | (pb_oe & pb_x);
  assign pc_i = (~pc_oe & pc_o) | (pc_oe & {a_hi[1], pc_x[6:3], a_hi[0], pc_x[1:0]});
  assign pd_i = (~pd_oe & pd_o) | (pd_oe & {pwd, dms_n, pd_x[0]});
  initial mclk = 1'b0;
  always #2.5 mclk = ~mclk;
  dpm_pin_mux u_dut (.mclk(mclk), .rst(rst), .ce(ce), .sys_reset_n(srst_n),
    .write_strobe_in(wr_n), .read_strobe_in(rd_n), .byte_space_select_in(bms_n),
    .bus_write_n(bwr), .bus_read_n(brd), .byte_access(bacc), .data_byte_pins_i(dbus),
    .data_byte_pins_o(dbo), .data_byte_pins_oe_n(dbo_oe), .data_in(din), .data_out(dout),
    .data_drive(ddrv), .page_we(pwe), .page(page), .cfg_we(cwe), .pb_fn_wr(pbf_w),
    .pb_out_wr(pbo_w), .pb_dir_wr(pbd_w), .pb_slew_wr(slw_w), .pb_od_wr(pbod_w),
    .pc_out_wr(pco_w), .pc_dir_wr(pcd_w), .pc_od_wr(pcod_w), .pc_mcell_wr(pcm_w),
    .pd_out_wr(pdo_w), .pd_dir_wr(pdd_w), .pd_cs_wr(pdc_w), .opt_jtag(ojt),
    .opt_prog_stat(ops), .opt_ready_busy(orb), .opt_clk_in(ock), .opt_flash_csel(ocs),
    .port_b_pins_i(pb_i), .port_b_pins_o(pb_o), .port_b_pins_oe_n(pb_oe),
    .port_b_fast_slew(slw), .port_b_open_drain(pb_od), .port_c_pins_i(pc_i),
    .port_c_pins_o(pc_o), .port_c_pins_oe_n(pc_oe), .port_c_open_drain(pc_od),
    .port_d_pins_i(pd_i), .port_d_pins_o(pd_o), .port_d_pins_oe_n(pd_oe),
    .output_macrocells_first_group(mc1), .output_macrocells_second_group(mc2),
    .logic_chip_selects(lcs), .port_b_logic_in(pb_li), .port_c_logic_in(pc_li),
    .port_d_logic_in(pd_li), .logic_common_clock(lclk), .tms(tms), .tck(tck), .tdi(tdi),
    .tdo(tdo), .program_status_pin(pst), .program_error_pin(per), .flash_busy(fbsy),
    .flash_enable(fen), .pb_read(pb_rd), .pc_read(pc_rd), .pd_read(pd_rd));
  dpm_dsp_model u_dsp (.mclk(mclk), .wr_n(wr_n), .rd_n(rd_n), .bms_n(bms_n), .d_drv(d_drv),
    .d_wire(dbus), .dms_n(dms_n), .pwd_ack(pwd), .a_hi(a_hi));
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic cfg;
    cwe = 1'b1;
    cyc(1);
    cwe = 1'b0;
    cyc(1);
  endtask
  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    {rst, ce, srst_n, ddrv, pwe, cwe, ojt, ops, orb, ock, ocs, tdo} = 12'hC00;
    {pst, per, fbsy, pbf_w, pbo_w, pbd_w, pco_w, pcd_w, pcod_w, pcm_w} = '0;
    {slw_w, pbod_w, pdo_w, pdd_w, pdc_w, lcs, pd_x, dout, mc1, mc2, pb_x, pc_x} = '0;
    cyc(8);
    rst = 1'b0;
    cyc(2);
    chk("page", 16'h0, page);
    chk("pb_oe", 16'hFF, pb_oe);
    srst_n = 1'b1;
    cyc(3);
    {pbf_w, pbd_w, slw_w} = 28'hE4E4_FF_A;
    {pbod_w, pcd_w, pco_w, pcod_w} = {5'h06, 24'hFF_3C_81};
    {pdd_w, pdo_w} = 6'h3D;
    for (int k = 0; k < 2; k++) begin
      {pbo_w, mc1, mc2} = k ? 24'h5A0020 : 24'hA50200;
      cfg();
      chk("pb_oe", 16'hCC, pb_oe);
      chk("pb_o", k ? 16'h30 : 16'h03, pb_o & 8'h33);
    end
    chk("slew", 16'hA, slw);
    chk("pb_od", 16'h30, pb_od);
    chk("pc_o", 16'h3C00, {pc_o, pc_oe});
    chk("pc_od", 16'h81, pc_od);
    chk("pd_o", 16'h50, {pd_o, 1'b0, pd_oe});
    {pdc_w, lcs} = 6'h12;
    cfg();
    chk("pd_cs", 16'h70, {pd_o, 1'b0, pd_oe});
    {pdd_w, pdc_w, pb_x, pd_x} = 17'h00_16_1;
    cfg();
    u_dsp.side(1'b0, 1'b1, 2'h3);
    cyc(3);
    chk("pb_rd", 16'h04, pb_rd & 8'h44);
    chk("pb_li", 16'h04, pb_li & 8'h44);
    chk("pd_li", 16'h5, pd_li);
    {ojt, ops, pst, tdo, pc_x} = 12'hF23;
    // Pins 2 and 7 become inputs so the upper address can reach the logic
    pcd_w = 8'h7B;
    cfg();
    cyc(2);
    chk("jtag", 16'h7, {tms, tck, tdi});
    chk("pc6", 16'hA4, {pc_o[6], pc_oe[6], pc_oe[5], 1'b0, pc_o[4:3], pc_oe[4:3]});
    chk("addr", 16'h3, {pc_li[7], pc_li[2]});
    chk("pc_rd", 16'h87, pc_rd & 8'h87);
    {ops, orb, fbsy} = 3'h3;
    cyc(1);
    chk("busy", 16'h0, {pc_o[3], pc_oe[3]});
    fbsy = 1'b0;
    cyc(1);
    chk("ready", 16'h2, {pc_o[3], pc_oe[3]});
    {ock, ocs} = 2'h3;
    for (int k = 0; k < 2; k++) begin
      u_dsp.side(k[0], !k[0], 2'h3);
      cyc(3);
      chk("clk_en", k ? 16'h3 : 16'h0, {lclk, fen});
    end
    u_dsp.start(1'b0, 1'b1, 8'hB6);
    cyc(4);
    chk("wr", 16'h1B6, {bwr, bacc, din});
    pwe = 1'b1;
    cyc(1);
    pwe = 1'b0;
    u_dsp.finish(rv);
    chk("page", 16'h6, page);
    cyc(1);
    {ddrv, dout} = 9'h15C;
    u_dsp.start(1'b1, 1'b0, 8'h00);
    cyc(4);
    chk("rd", 16'h0000, {brd, bacc, dbo_oe});
    u_dsp.finish(rv);
    chk("rdata", 16'h5C, rv);
    ddrv = 1'b0;
    srst_n = 1'b0;
    cyc(4);
    chk("srst", 16'h0FF, {page, pb_oe});
    srst_n = 1'b1;
    cyc(3);
    wrap_up();
  end
endmodule
